// >>> mcodec_dma_model.sv
// behavioural dma controller serving the codec's peripheral requests
`timescale 1ns/10ps
`default_nettype none
module mcodec_dma_model (
  input wire logic clock_i,
  input wire logic slow_i,
  input wire logic dma_in_req_i,
  output logic dma_in_ack_o,
  output logic [7:0] dma_in_data_o,
  input wire logic dma_out_req_i,
  output logic dma_out_ack_o,
  input wire logic [7:0] dma_out_data_i
);
  logic [7:0] in_q[$];
  logic [7:0] out_q[$];
  logic [1:0] wait_q = 2'd0;
  initial begin
    dma_in_ack_o = 1'b0;
    dma_out_ack_o = 1'b0;
    dma_in_data_o = 8'ha5;
  end
  // one ack per request and never two in a row, as req is registered
  always @(posedge clock_i) begin
    wait_q <= wait_q + 2'd1;
    dma_in_ack_o <= 1'b0;
    dma_out_ack_o <= 1'b0;
    dma_in_data_o <= ~dma_in_data_o; // idle bus keeps moving
    if (!slow_i || wait_q == 2'd3) begin
      if (dma_in_req_i && !dma_in_ack_o && in_q.size() > 0) begin
        dma_in_ack_o <= 1'b1;
        dma_in_data_o <= in_q.pop_front();
      end else if (dma_out_req_i && !dma_out_ack_o) begin
        dma_out_ack_o <= 1'b1;
        out_q.push_back(dma_out_data_i);
      end
    end
  end
endmodule : mcodec_dma_model
`default_nettype wire

// >>> mcodec_man.sv
// manchester nibble coder and byte checker
`timescale 1ns/10ps
`default_nettype none
module mcodec_man (
  input wire logic [7:0] enc_in_i,
  input wire logic [7:0] dec_hi_i,
  input wire logic [7:0] dec_lo_i,
  output logic [15:0] enc_out_o,
  output logic [7:0] dec_out_o,
  output logic dec_bad_o
);
  import mcodec_pkg::*;

  logic [1:0] pair_ok;
  logic [7:0] raw;

  // each bit: 0 -> 10, 1 -> 01, msb first
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign enc_out_o[2*g+1] = ~enc_in_i[g];
      assign enc_out_o[2*g] = enc_in_i[g];
    end
    for (g = 0; g < 4; g++) begin : g_chk
      assign raw[g+4] = dec_hi_i[2*g];
      assign raw[g] = dec_lo_i[2*g];
    end
  endgenerate

  // a byte is valid only if every bit pair differs
  assign pair_ok[1] = ((dec_hi_i ^ (dec_hi_i >> 1)) & 8'h00_55) == 8'h00_55;
  assign pair_ok[0] = ((dec_lo_i ^ (dec_lo_i >> 1)) & 8'h00_55) == 8'h00_55;
  assign dec_bad_o = ~&pair_ok;
  assign dec_out_o = dec_bad_o ? MC_BAD_BYTE : raw;
endmodule : mcodec_man
`default_nettype wire

// >>> mcodec_pkg.sv
// shared constants for the manchester / three-of-six line-code engine
`default_nettype none
package mcodec_pkg;
  // register addresses on the special-register bus
  localparam logic [7:0] MC_ADDR_LOW = 8'h00_c2;
  localparam logic [7:0] MC_ADDR_MID = 8'h00_c3;
  localparam logic [7:0] MC_ADDR_HIGH = 8'h00_c4;
  localparam logic [7:0] MC_ADDR_CTRL = 8'h00_c5;
  // reset values
  localparam logic [7:0] MC_DATA_RST = 8'h00_00;
  localparam logic [7:0] MC_CTRL_RST = 8'h00_00;
  // control register field positions
  localparam int MC_BIT_READY = 7;
  localparam int MC_BIT_ERROR = 6;
  localparam int MC_BIT_ENC = 5;
  localparam int MC_BIT_DEC = 4;
  localparam int MC_BIT_DMA = 2;
  localparam int MC_BIT_ENDIAN = 1;
  localparam int MC_BIT_MODE = 0;
  // value of a failed manchester decode
  localparam logic [7:0] MC_BAD_BYTE = 8'h00_ff;
  // dma group sizes in bytes: [encode/decode][mode]
  localparam logic [1:0] MC_N_MAN_ENC_IN = 2'd1;
  localparam logic [1:0] MC_N_MAN_DEC_IN = 2'd2;
  localparam logic [1:0] MC_N_TOS_ENC_IN = 2'd2;
  localparam logic [1:0] MC_N_TOS_DEC_IN = 2'd3;
  localparam logic [1:0] MC_N_MAN_ENC_OUT = 2'd2;
  localparam logic [1:0] MC_N_MAN_DEC_OUT = 2'd1;
  localparam logic [1:0] MC_N_TOS_ENC_OUT = 2'd3;
  localparam logic [1:0] MC_N_TOS_DEC_OUT = 2'd2;
  // dma request selector codes seen by the dma controller
  localparam logic [7:0] MC_DMA_SEL_IN = 8'h00_00;
  localparam logic [7:0] MC_DMA_SEL_OUT = 8'h00_01;

  // engine states, gray along idle->load->run->drain
  typedef enum logic [1:0] {
    MC_IDLE = 2'b00,
    MC_LOAD = 2'b01,
    MC_RUN = 2'b11,
    MC_DRAIN = 2'b10
  } mc_state_t;
endpackage : mcodec_pkg
`default_nettype wire

// >>> mcodec_top.sv
// register-mapped manchester / three-of-six line-code engine
// Functional notes
// - manchester encode: high nibble mid, low nibble low
// - bit zero sends 10, one sends 01
// - mode bit: 0 manchester, 1 three-of-six
// - manchester decode two bytes; bad gives error, ff
// - decode inverts encode; other bytes are invalid
// - three-of-six encode two bytes into three
// - fixed sixteen-symbol table, three ones each
// - three-of-six decode three bytes; bad symbol flags error
// - data right justified; manchester leaves high unused
// - inputs readable until start; result replaces them
// - start bits self-clear; ready set, never hardware-cleared
// - software clears flags, allowed in start write
// - interrupt request raised on decode error
// - dma decode errors do not halt, flag sticks
// - big-endian bit orders multi-byte dma data
// - dma mode moves data by peripheral requests
// - input request code 0, output request code 1
`timescale 1ns/10ps
`default_nettype none
module mcodec_top (
  input wire logic clock_i,
  input wire logic arst_n_i,
  // special-register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // dma peripheral requests and data path
  output logic dma_in_req_o,
  input wire logic dma_in_ack_i,
  input wire logic [7:0] dma_in_data_i,
  output logic dma_out_req_o,
  input wire logic dma_out_ack_i,
  output logic [7:0] dma_out_data_o,
  // decode error interrupt request
  output logic err_irq_o
);
  import mcodec_pkg::*;

  logic [7:0] low_q, mid_q, high_q;
  logic ready_q, error_q, enc_q, dec_q, dma_q, endian_q, mode_q;
  logic [7:0] rdata_q;
  logic dma_in_req_q, dma_out_req_q;
  logic [7:0] dma_out_data_q;
  mc_state_t state_q;
  logic dma_op_q; // latched encode(1)/decode(0) for register runs and dma streaming
  logic [1:0] cnt_q;
  logic [15:0] man_enc;
  logic [7:0] man_dec;
  logic man_bad;
  logic [23:0] tos_enc;
  logic [15:0] tos_dec;
  logic tos_bad;
  logic wr_ctrl, go_enc, go_dec, run_now, run_enc, op_bad;
  logic abort;
  logic [23:0] result;
  logic [1:0] n_in, n_out;
  logic in_take, out_take;
  logic [7:0] out_byte;

  // manchester path only ever sees the low two bytes
  mcodec_man u_man (
    .enc_in_i(low_q),
    .dec_hi_i(mid_q),
    .dec_lo_i(low_q),
    .enc_out_o(man_enc),
    .dec_out_o(man_dec),
    .dec_bad_o(man_bad)
  );

  mcodec_tos u_tos (
    .enc_in_i({mid_q, low_q}),
    .dec_in_i({high_q, mid_q, low_q}),
    .enc_out_o(tos_enc),
    .dec_out_o(tos_dec),
    .dec_bad_o(tos_bad)
  );

  // decode of the control write and the run strobe
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == MC_ADDR_CTRL);
  assign go_enc = wr_ctrl && sfr_wdata_i[MC_BIT_ENC];
  assign go_dec = wr_ctrl && sfr_wdata_i[MC_BIT_DEC];
  // control rewrite without the dma bit or a start bit abandons a running stream
  assign abort = wr_ctrl && !sfr_wdata_i[MC_BIT_DMA] && dma_q
    && state_q != MC_IDLE && !go_enc && !go_dec;
  // register runs start one cycle after the write, dma runs from run state
  assign run_now = (state_q == MC_RUN);
  assign run_enc = dma_op_q;

  // result selection by mode and direction, right justified
  // the high byte passes through untouched in manchester mode
  always_comb begin
    result = {high_q, mid_q, low_q};
    op_bad = 1'b0;
    if (mode_q) begin
      if (run_enc) begin
        result = tos_enc;
      end else begin
        result = {8'h00_00, tos_dec};
        op_bad = tos_bad;
      end
    end else begin
      if (run_enc) begin
        result = {high_q, man_enc};
      end else begin
        result = {high_q, 8'h00_00, man_dec};
        op_bad = man_bad;
      end
    end
  end

  // group sizes for the dma sequencer
  always_comb begin
    unique case ({dma_op_q, mode_q})
      2'b10: begin
        n_in = MC_N_MAN_ENC_IN;
        n_out = MC_N_MAN_ENC_OUT;
      end
      2'b11: begin
        n_in = MC_N_TOS_ENC_IN;
        n_out = MC_N_TOS_ENC_OUT;
      end
      2'b00: begin
        n_in = MC_N_MAN_DEC_IN;
        n_out = MC_N_MAN_DEC_OUT;
      end
      2'b01: begin
        n_in = MC_N_TOS_DEC_IN;
        n_out = MC_N_TOS_DEC_OUT;
      end
    endcase
  end

  assign in_take = dma_in_req_q && dma_in_ack_i && state_q == MC_LOAD;
  assign out_take = dma_out_req_q && dma_out_ack_i && state_q == MC_DRAIN;

  // byte offered to the dma: most significant first in big-endian
  always_comb begin
    logic [1:0] idx;
    idx = endian_q ? 2'(cnt_q - 2'd1) : 2'(n_out - cnt_q);
    unique case (idx)
      2'd2: out_byte = high_q;
      2'd1: out_byte = mid_q;
      default: out_byte = low_q;
    endcase
  end

  // sequencer: register runs take one cycle, dma loops over groups
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= MC_IDLE;
      dma_op_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      unique case (state_q)
        MC_IDLE: begin
          if (go_enc || go_dec) begin
            dma_op_q <= go_enc;
            cnt_q <= 2'd0;
            state_q <= sfr_wdata_i[MC_BIT_DMA] ? MC_LOAD : MC_RUN;
          end
        end
        MC_LOAD: begin
          if (in_take) begin
            cnt_q <= 2'(cnt_q + 2'd1);
            if (2'(cnt_q + 2'd1) == n_in) begin
              state_q <= MC_RUN;
            end
          end
        end
        MC_RUN: begin
          // coding is combinational, so one cycle covers every mode
          cnt_q <= n_out;
          state_q <= dma_q ? MC_DRAIN : MC_IDLE;
        end
        MC_DRAIN: begin
          if (out_take) begin
            cnt_q <= 2'(cnt_q - 2'd1);
            if (cnt_q == 2'd1) begin
              state_q <= MC_LOAD;
            end
          end
        end
      endcase
      // clearing the control register abandons a stream
      if (abort) begin
        state_q <= MC_IDLE;
      end
    end
  end

  // dma request lines, one byte per handshake
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_in_req_q <= 1'b0;
      dma_out_req_q <= 1'b0;
      dma_out_data_q <= MC_DATA_RST;
    end else begin
      // dropped on the abort edge so no byte is fetched for a dead stream
      dma_in_req_q <= (state_q == MC_LOAD) && !in_take
        && !abort;
      dma_out_req_q <= (state_q == MC_DRAIN) && !out_take
        && !abort;
      dma_out_data_q <= out_byte;
    end
  end

  // data registers: bus writes, dma fill, result overwrite
  // a bus write in the run cycle or in a cycle that takes a dma byte is lost; software must
  // wait for ready before loading the next group
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_q <= MC_DATA_RST;
      mid_q <= MC_DATA_RST;
      high_q <= MC_DATA_RST;
    end else if (run_now) begin
      {high_q, mid_q, low_q} <= result;
    end else if (in_take) begin
      // shift in: first byte ends highest when big-endian
      if (endian_q) begin
        {high_q, mid_q, low_q} <= {mid_q, low_q, dma_in_data_i};
      end else begin
        unique case (cnt_q)
          2'd0: low_q <= dma_in_data_i;
          2'd1: mid_q <= dma_in_data_i;
          default: high_q <= dma_in_data_i;
        endcase
      end
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == MC_ADDR_LOW) low_q <= sfr_wdata_i;
      if (sfr_addr_i == MC_ADDR_MID) mid_q <= sfr_wdata_i;
      if (sfr_addr_i == MC_ADDR_HIGH) high_q <= sfr_wdata_i;
    end
  end

  // control register bits; start bits pulse for one cycle only
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {enc_q, dec_q} <= 2'b00;
      {dma_q, endian_q, mode_q} <= 3'b000;
    end else begin
      enc_q <= go_enc && !sfr_wdata_i[MC_BIT_DEC];
      dec_q <= go_dec && !sfr_wdata_i[MC_BIT_ENC];
      if (wr_ctrl) begin
        dma_q <= sfr_wdata_i[MC_BIT_DMA];
        endian_q <= sfr_wdata_i[MC_BIT_ENDIAN];
        mode_q <= sfr_wdata_i[MC_BIT_MODE];
      end
    end
  end

  // ready and error: software clears, completion sets and wins
  // a clear meeting a completion loses, so no result goes unseen
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      if (run_now) begin
        ready_q <= 1'b1;
      end else if (wr_ctrl && !sfr_wdata_i[MC_BIT_READY]) begin
        ready_q <= 1'b0;
      end
      if (run_now && !run_enc && op_bad) begin
        error_q <= 1'b1;
      end else if (wr_ctrl && !sfr_wdata_i[MC_BIT_ERROR]) begin
        error_q <= 1'b0;
      end
    end
  end

  // read data and interrupt, both registered
  // idle and unmapped reads return zero so stray reads are harmless
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= MC_DATA_RST;
      err_irq_o <= 1'b0;
    end else begin
      err_irq_o <= error_q;
      rdata_q <= MC_DATA_RST;
      if (sfr_rd_i) begin
        unique case (sfr_addr_i)
          MC_ADDR_LOW: rdata_q <= low_q;
          MC_ADDR_MID: rdata_q <= mid_q;
          MC_ADDR_HIGH: rdata_q <= high_q;
          MC_ADDR_CTRL: rdata_q <= {ready_q, error_q, enc_q, dec_q, 1'b0,
                                    dma_q, endian_q, mode_q};
          default: rdata_q <= MC_DATA_RST;
        endcase
      end
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign dma_in_req_o = dma_in_req_q;
  assign dma_out_req_o = dma_out_req_q;
  assign dma_out_data_o = dma_out_data_q;
endmodule : mcodec_top
`default_nettype wire

// >>> mcodec_top_assertions.sv
// port-level checker for the line-code engine, bound to mcodec_top
`timescale 1ns/10ps
`default_nettype none
module mcodec_top_checker (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic dma_in_req_o,
  input wire logic dma_in_ack_i,
  input wire logic [7:0] dma_in_data_i,
  input wire logic dma_out_req_o,
  input wire logic dma_out_ack_i,
  input wire logic [7:0] dma_out_data_o,
  input wire logic err_irq_o
);
  import mcodec_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  // control writes without the dma bit or a start bit end a pending request, so all control writes are excluded from holds
  logic ctl_wr;
  assign ctl_wr = sfr_wr_i && sfr_addr_i == MC_ADDR_CTRL;

  a_rdata_idle: assert property (sfr_rdata_o != 8'h00 |-> $past(sfr_rd_i))
    else $error("read data without a read");
  a_unmapped_read: assert property (sfr_rd_i
    && (sfr_addr_i < MC_ADDR_LOW || sfr_addr_i > MC_ADDR_CTRL)
    |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_irq_matches: assert property (sfr_rd_i
    && sfr_addr_i == MC_ADDR_CTRL
    |=> sfr_rdata_o[MC_BIT_ERROR] == err_irq_o)
    else $error("interrupt differs from error flag");
  a_start_clear: assert property (sfr_rd_i
    && sfr_addr_i == MC_ADDR_CTRL
    |=> sfr_rdata_o[MC_BIT_ENC:MC_BIT_DEC] == 2'b00)
    else $error("start bit did not clear");
  a_dma_starts: assert property (ctl_wr
    && sfr_wdata_i[MC_BIT_DMA] && |sfr_wdata_i[5:4]
    |-> ##[1:3] dma_in_req_o)
    else $error("no input request after dma start");
  a_dma_stops: assert property (ctl_wr
    && !sfr_wdata_i[MC_BIT_DMA] |-> ##2 !dma_in_req_o && !dma_out_req_o)
    else $error("request after dma mode left");
  a_req_exclusive: assert property (
    !(dma_in_req_o && dma_out_req_o))
    else $error("input and output requested together");
  a_in_hold: assert property (dma_in_req_o
    && !dma_in_ack_i && !ctl_wr |=> dma_in_req_o)
    else $error("input request dropped unserved");
  a_out_hold: assert property (dma_out_req_o
    && !dma_out_ack_i && !ctl_wr
    |=> dma_out_req_o && $stable(dma_out_data_o))
    else $error("output byte changed before taken");
  a_reset_quiet: assert property ($rose(arst_n_i)
    |-> !dma_in_req_o && !dma_out_req_o && !err_irq_o)
    else $error("outputs active after reset");
endmodule : mcodec_top_checker

bind mcodec_top mcodec_top_checker u_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .dma_in_req_o(dma_in_req_o),
  .dma_in_ack_i(dma_in_ack_i), .dma_in_data_i(dma_in_data_i),
  .dma_out_req_o(dma_out_req_o), .dma_out_ack_i(dma_out_ack_i),
  .dma_out_data_o(dma_out_data_o), .err_irq_o(err_irq_o)
);
`default_nettype wire

// >>> mcodec_tos.sv
// three-out-of-six symbol coder for four nibbles and four symbols
`timescale 1ns/10ps
`default_nettype none
module mcodec_tos (
  input wire logic [15:0] enc_in_i,
  input wire logic [23:0] dec_in_i,
  output logic [23:0] enc_out_o,
  output logic [15:0] dec_out_o,
  output logic dec_bad_o
);
  import mcodec_pkg::*;

  localparam logic [95:0] SYM_TAB = {
    6'b101001, 6'b110010, 6'b110001, 6'b110100,
    6'b100011, 6'b100110, 6'b100101, 6'b101100,
    6'b010011, 6'b011010, 6'b011001, 6'b011100,
    6'b001011, 6'b001110, 6'b001101, 6'b010110};

  logic [3:0] bad;

  // reverse lookup by searching the table
  function automatic logic [4:0] sym_dec(input logic [5:0] s);
    logic [4:0] r;
    r = 5'h10;
    for (int k = 0; k < 16; k++) begin
      if (SYM_TAB[k*6 +: 6] == s) begin
        r = {1'b0, 4'(k)};
      end
    end
    return r;
  endfunction : sym_dec

  // top nibble lands in the top six bits
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_nib
      logic [4:0] d;
      assign enc_out_o[g*6 +: 6] = SYM_TAB[enc_in_i[g*4 +: 4]*6 +: 6];
      assign d = sym_dec(dec_in_i[g*6 +: 6]);
      assign dec_out_o[g*4 +: 4] = d[3:0];
      assign bad[g] = d[4];
    end
  endgenerate

  assign dec_bad_o = |bad;
endmodule : mcodec_tos
`default_nettype wire

// >>> tb.sv
// self-checking bench for the line-code engine
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mcodec_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic slow = 1'b0;
  logic [7:0] sfr_rdata_o, dma_in_data_i, dma_out_data_o, rv;
  logic dma_in_req_o, dma_in_ack_i, dma_out_req_o, dma_out_ack_i, err_irq_o;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  mcodec_top DUT (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
    .dma_in_req_o(dma_in_req_o), .dma_in_ack_i(dma_in_ack_i),
    .dma_in_data_i(dma_in_data_i), .dma_out_req_o(dma_out_req_o),
    .dma_out_ack_i(dma_out_ack_i), .dma_out_data_o(dma_out_data_o),
    .err_irq_o(err_irq_o));
  mcodec_dma_model u_dma (.clock_i(clock_i), .slow_i(slow),
    .dma_in_req_i(dma_in_req_o), .dma_in_ack_o(dma_in_ack_i),
    .dma_in_data_o(dma_in_data_i), .dma_out_req_i(dma_out_req_o),
    .dma_out_ack_o(dma_out_ack_i), .dma_out_data_i(dma_out_data_o));

  // clock and hang guard; tests need well under 2000 cycles
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : cmp

  // bus cycles: strobe held one edge, read data sampled after the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clock_i);
    sfr_rd_i <= 1'b0;
    #1 rv = sfr_rdata_o;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [7:0] e, input string n);
    rd(a);
    cmp(n, e, rv);
  endtask : chk

  // register-driven operation, polling ready a bounded number of times
  task automatic op(input logic [7:0] c, input logic [23:0] d);
    int i;
    wr(MC_ADDR_HIGH, d[23:16]);
    wr(MC_ADDR_MID, d[15:8]);
    wr(MC_ADDR_LOW, d[7:0]);
    chk(MC_ADDR_LOW, d[7:0], "low before start");
    wr(MC_ADDR_CTRL, c);
    i = 0;
    rv = 8'h00;
    while (rv[MC_BIT_READY] !== 1'b1 && i < 8) begin
      rd(MC_ADDR_CTRL);
      i++;
    end
  endtask : op

  // nb result bytes are compared, right justified, low even when nb is 0, plus the control value
  task automatic res(input logic [7:0] ec, input logic [23:0] e, input int nb);
    chk(MC_ADDR_CTRL, ec, "control");
    chk(MC_ADDR_LOW, e[7:0], "low");
    if (nb > 1) chk(MC_ADDR_MID, e[15:8], "mid");
    if (nb > 2) chk(MC_ADDR_HIGH, e[23:16], "high");
    $display("op test done ctrl %h", ec);
  endtask : res

  // dma stream: n input bytes big-endian, m result bytes expected
  task automatic dma(input logic [7:0] c, input int n, input logic [31:0] d,
      input int m, input logic [23:0] e, input logic s);
    int i;
    // let a stopped stream's request fall before the model gets new bytes
    repeat (2) @(posedge clock_i);
    for (i = n - 1; i >= 0; i--) u_dma.in_q.push_back(d[8*i+:8]);
    slow <= s;
    wr(MC_ADDR_CTRL, c);
    i = 0;
    while (u_dma.out_q.size() < m && i < 400) begin
      @(posedge clock_i);
      i++;
    end
    rd(MC_ADDR_CTRL);
    if (rv[MC_BIT_ERROR]) u_dma.in_q.delete();
    wr(MC_ADDR_CTRL, 8'h00);
    for (i = m - 1; i >= 0; i--) begin
      if (u_dma.out_q.size() > 0)
        cmp("dma byte", e[8*i+:8], u_dma.out_q.pop_front());
      else cmp("dma byte", e[8*i+:8], 8'hxx);
    end
    $display("dma test done ctrl %h", c);
  endtask : dma

  // main sequence
  initial begin
    int a;
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (a = 'hc2; a <= 'hc6; a++) chk(8'(a), MC_DATA_RST, "reset value");
    wr(MC_ADDR_CTRL, 8'h00);
    op(8'h20, 24'h5c_003c);
    res(8'h80, 24'h5c_a55a, 3);
    op(8'h10, 24'h00_55aa);
    res(8'h80, 24'h00_00f0, 1);
    op(8'h10, 24'h00_aa55);
    res(8'h80, 24'h00_000f, 1);
    op(8'h10, 24'h00_00aa);
    res(8'hc0, 24'h00_00ff, 1);
    cmp("irq", 8'h01, {7'h0, err_irq_o});
    op(8'h21, 24'h00_01f0);
    res(8'h81, 24'h58_da56, 3);
    op(8'h11, 24'h58_da56);
    res(8'h81, 24'h00_01f0, 2);
    op(8'h11, 24'h00_0000);
    res(8'hc1, 24'h00_0000, 0);
    dma(8'h26, 1, 32'h0000_003c, 2, 24'h00_a55a, 1'b0);
    dma(8'h27, 2, 32'h0000_01f0, 3, 24'h58_da56, 1'b1);
    dma(8'h17, 3, 32'h0058_da56, 2, 24'h00_01f0, 1'b0);
    dma(8'h16, 4, 32'haa55_0000, 2, 24'h00_0fff, 1'b1);
    cmp("dma error", 8'h40, rv & 8'h40);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
